// file: fault_cfg.svh
// Constants shared by the fault recorder and its clear controller.
// Assumes inclusion by bare name from package, interface and modules.
`ifndef FAULT_CFG_SVH
`define FAULT_CFG_SVH

`define LINK_AW         16
`define DATA_W          32
`define MEDIA_REC_OFS   16'h4194
`define BLT_REC_OFS     16'h4294
`define IIR_OFS         16'h40A4
`define EIR_OFS         16'h40B0
`define ESR_OFS         16'h40B4
`define EMR_OFS         16'h40B8

`define REC_VALID_BIT   0
`define REC_RSVD_W      2
`define REC_SEL_BIT     11
`define REC_SRC_W       8
`define REC_VPAGE_W     20

`define ERR_W           8
`define ERR_PGTBL       0
`define ERR_MEDIA       1
`define ERR_BLT         2
`define ERR_OP_LO       3
`define ERR_OP_W        5
`define EMR_RST         8'hFF
`define IIR_MASTER_BIT  15

`define APB_AW          8
`define C_CTRL          8'h00
`define C_STATUS        8'h04
`define C_ACC_ADDR      8'h08
`define C_ACC_WDATA     8'h0C
`define C_ACC_RDATA     8'h10
`define C_CLR_CFG       8'h14
`define C_INT_STATUS    8'h18
`define C_INT_MASK      8'h1C
`define CTRL_START      0
`define CTRL_GO         1
`define CTRL_WR         2
`define CFG_MEDIA       0
`define CFG_BLT         1
`define CFG_EIR_LO      8
`define INT_SEQ         0
`define INT_ACC         1
`define INT_MERR        2
`define INT_W           3

`endif

// file: fault_pkg.sv
// Types for the fault recorder and the clear controller.
// Assumes fault_cfg.svh is on the include path.
`include "fault_cfg.svh"
package fault_pkg;

  typedef struct packed {
    logic [`REC_VPAGE_W-1:0] vpage;
    logic                    sel;
    logic [`REC_SRC_W-1:0]   src;
    logic                    valid;
  } rec_t;

  typedef struct packed {
    rec_t                media;
    rec_t                blt;
    logic [`ERR_W-1:0]   error_status_register;
    logic [`ERR_W-1:0]   error_identity_register;
    logic [`ERR_W-1:0]   error_mask_register;
    logic                master;
    logic                ack;
    logic [`DATA_W-1:0]  rdata;
    logic                media_inv;
    logic                blt_inv;
  } dev_state_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_MED  = 3'b001,
    S_BLT  = 3'b010,
    S_EIR  = 3'b011,
    S_IIR  = 3'b100,
    S_ACC  = 3'b101
  } seq_t;

  typedef struct packed {
    seq_t                seq;
    logic                req;
    logic                we;
    logic [`LINK_AW-1:0] addr;
    logic [`DATA_W-1:0]  wdata;
    logic [`LINK_AW-1:0] acc_addr;
    logic [`DATA_W-1:0]  acc_wdata;
    logic [`DATA_W-1:0]  acc_rdata;
    logic                acc_we;
    logic                clr_media;
    logic                clr_blt;
    logic [`ERR_W-1:0]   clr_eir;
    logic [`INT_W-1:0]   int_st;
    logic [`INT_W-1:0]   int_mask;
    logic                merr_q;
    logic                irq;
    logic [`DATA_W-1:0]  prdata;
    logic                pready;
  } ctl_state_t;

endpackage

// file: fault_link_if.sv
// Register link between the fault recorder and its clear controller.
// Assumes both ends share clk_i; req holds until a one-cycle ack.
`include "fault_cfg.svh"
`timescale 1ns/1ps
interface fault_link_if;
  logic                req;
  logic                we;
  logic [`LINK_AW-1:0] addr;
  logic [`DATA_W-1:0]  wdata;
  logic                ack;
  logic [`DATA_W-1:0]  rdata;
  logic                master_err;

  modport dev (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    output ack,
    output rdata,
    output master_err
  );

  modport ctl (
    output req,
    output we,
    output addr,
    output wdata,
    input  ack,
    input  rdata,
    input  master_err
  );
endinterface

// file: fault_recorder.sv
// First page fault records for media and blitter engines, plus the
// error status, identity, mask and master interrupt registers.
// Assumes the translation unit gives one-cycle fault strobes with
// address, source and table select valid in the same cycle.
`include "fault_cfg.svh"
`timescale 1ns/1ps
module fault_recorder (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  fault_link_if.dev                   lk,
  input  wire logic                   media_fault_i,
  input  wire logic [`REC_VPAGE_W-1:0] media_vpage_i,
  input  wire logic                   media_sel_i,
  input  wire logic [`REC_SRC_W-1:0]   media_src_i,
  input  wire logic                   blt_fault_i,
  input  wire logic [`REC_VPAGE_W-1:0] blt_vpage_i,
  input  wire logic                   blt_sel_i,
  input  wire logic [`REC_SRC_W-1:0]   blt_src_i,
  input  wire logic                   pgtbl_err_i,
  input  wire logic [`ERR_OP_W-1:0]    op_err_i,
  output logic                        media_cycle_invalid_o,
  output logic                        blt_cycle_invalid_o
);
  import fault_pkg::*;

  dev_state_t        s;
  dev_state_t        next_s;
  logic              taken;
  logic              wr;
  logic [`ERR_W-1:0] eir_clr;
  logic              iir_clr;
  logic [`ERR_W-1:0] set_v;
  logic [`ERR_W-1:0] keep_mask;

  // Capture only while disarmed record is empty
  function automatic rec_t rec_capture(
    input rec_t                    r,
    input logic                    f,
    input logic [`REC_VPAGE_W-1:0] vp,
    input logic                    sel,
    input logic [`REC_SRC_W-1:0]   src
  );
    rec_t c;
    c = r;
    if (f && !r.valid) begin
      c.vpage = vp;
      c.sel   = sel;
      c.src   = src;
      c.valid = 1'b1;
    end
    return c;
  endfunction

  // Reserved bits always read zero
  function automatic logic [`DATA_W-1:0] rec_word(input rec_t r);
    return {r.vpage, r.sel, r.src, {`REC_RSVD_W{1'b0}}, r.valid};
  endfunction

  function automatic logic [`DATA_W-1:0] reg_read(
    input dev_state_t          st,
    input logic [`LINK_AW-1:0] a
  );
    logic [`DATA_W-1:0] d;
    d = '0;
    unique case (a)
      `MEDIA_REC_OFS: d = rec_word(st.media);
      `BLT_REC_OFS:   d = rec_word(st.blt);
      `EIR_OFS:       d = `DATA_W'(st.error_identity_register);
      `ESR_OFS:       d = `DATA_W'(st.error_status_register);
      `EMR_OFS:       d = `DATA_W'(st.error_mask_register);
      `IIR_OFS:       d[`IIR_MASTER_BIT] = st.master;
      default:        d = '0;
    endcase
    return d;
  endfunction

  // A record write clears only when bit 0 is written as zero
  function automatic logic rec_clear(
    input logic                wr_en,
    input logic [`LINK_AW-1:0] a,
    input logic [`LINK_AW-1:0] ofs,
    input logic [`DATA_W-1:0]  wd
  );
    return wr_en && (a == ofs) && !wd[`REC_VALID_BIT];
  endfunction

  always_comb begin
    next_s    = s;
    taken     = lk.req && !s.ack;
    wr        = taken && lk.we;
    eir_clr   = '0;
    iir_clr   = 1'b0;
    set_v     = '0;
    keep_mask = '0;

    next_s.ack = taken;
    if (taken && !lk.we) begin
      next_s.rdata = reg_read(s, lk.addr);
    end

    // Clear first so a fault in the same cycle still records
    if (rec_clear(wr, lk.addr, `MEDIA_REC_OFS, lk.wdata)) begin
      next_s.media = '0;
    end
    if (rec_clear(wr, lk.addr, `BLT_REC_OFS, lk.wdata)) begin
      next_s.blt = '0;
    end
    next_s.media = rec_capture(next_s.media, media_fault_i,
                               media_vpage_i, media_sel_i, media_src_i);
    next_s.blt   = rec_capture(next_s.blt, blt_fault_i,
                               blt_vpage_i, blt_sel_i, blt_src_i);

    if (wr && lk.addr == `EIR_OFS) begin
      eir_clr = lk.wdata[`ERR_W-1:0];
    end
    if (wr && lk.addr == `EMR_OFS) begin
      next_s.error_mask_register = lk.wdata[`ERR_W-1:0];
    end
    if (wr && lk.addr == `IIR_OFS) begin
      iir_clr = lk.wdata[`IIR_MASTER_BIT];
    end

    // Page table error survives any clear until reset
    keep_mask[`ERR_PGTBL] = 1'b1;
    eir_clr = eir_clr & ~keep_mask;

    // Record valid levels hold their status bits, so a record must be
    // cleared before its identity bit will stay clear.
    set_v[`ERR_PGTBL] = pgtbl_err_i;
    set_v[`ERR_MEDIA] = s.media.valid || media_fault_i;
    set_v[`ERR_BLT]   = s.blt.valid || blt_fault_i;
    set_v[`ERR_OP_LO +: `ERR_OP_W] = op_err_i;

    // Sources win over a clear in the same cycle
    next_s.error_status_register = (s.error_status_register & ~eir_clr) | set_v;
    next_s.error_identity_register = (s.error_identity_register & ~eir_clr) | (set_v & ~s.error_mask_register);

    // Master stays up while any identity bit remains
    next_s.master = (s.master && !iir_clr) || (|s.error_identity_register);

    next_s.media_inv = media_fault_i;
    next_s.blt_inv   = blt_fault_i;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s     <= '0;
      s.error_mask_register <= `EMR_RST;
    end else begin
      s <= next_s;
    end
  end

  assign lk.ack                = s.ack;
  assign lk.rdata              = s.rdata;
  assign lk.master_err         = s.master;
  assign media_cycle_invalid_o = s.media_inv;
  assign blt_cycle_invalid_o   = s.blt_inv;

endmodule

// file: fault_clear_ctl.sv
// Clear controller: APB slave that runs the error clear sequence and
// single register accesses over the link to the fault recorder.
// Assumes APB master in the same clock domain; zero wait states.
//
// The implementer's own choice: the APB register port.
`include "fault_cfg.svh"
`timescale 1ns/1ps
module fault_clear_ctl (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  fault_link_if.ctl               lk,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [`APB_AW-1:0] paddr_i,
  input  wire logic [`DATA_W-1:0] pwdata_i,
  output logic      [`DATA_W-1:0] prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  output logic                    irq_o
);
  import fault_pkg::*;

  ctl_state_t       s;
  ctl_state_t       next_s;
  logic             apb_wr;
  logic [`INT_W-1:0] int_set;
  logic [`INT_W-1:0] int_clr;

  // Source records first, then identity, then master
  function automatic seq_t step_after(input seq_t st, input ctl_state_t c);
    seq_t n;
    n = S_IDLE;
    unique case (st)
      S_IDLE:  n = c.clr_media ? S_MED : (c.clr_blt ? S_BLT : S_EIR);
      S_MED:   n = c.clr_blt ? S_BLT : S_EIR;
      S_BLT:   n = S_EIR;
      S_EIR:   n = S_IIR;
      S_IIR:   n = S_IDLE;
      S_ACC:   n = S_IDLE;
      default: n = S_IDLE;
    endcase
    return n;
  endfunction

  function automatic logic [`DATA_W-1:0] apb_read(
    input ctl_state_t         c,
    input logic [`APB_AW-1:0] a
  );
    logic [`DATA_W-1:0] d;
    d = '0;
    unique case (a)
      `C_STATUS: begin
        d[0] = (c.seq != S_IDLE);
        d[1] = lk.master_err;
      end
      `C_ACC_ADDR:   d = `DATA_W'(c.acc_addr);
      `C_ACC_WDATA:  d = c.acc_wdata;
      `C_ACC_RDATA:  d = c.acc_rdata;
      `C_CLR_CFG: begin
        d[`CFG_MEDIA] = c.clr_media;
        d[`CFG_BLT]   = c.clr_blt;
        d[`CFG_EIR_LO +: `ERR_W] = c.clr_eir;
      end
      `C_INT_STATUS: d = `DATA_W'(c.int_st);
      `C_INT_MASK:   d = `DATA_W'(c.int_mask);
      default:       d = '0;
    endcase
    return d;
  endfunction

  always_comb begin
    next_s  = s;
    apb_wr  = psel_i && penable_i && pwrite_i && s.pready;
    int_set = '0;
    int_clr = '0;
    next_s.pready = 1'b1;
    if (psel_i && !penable_i && !pwrite_i) begin
      next_s.prdata = apb_read(s, paddr_i);
    end

    if (apb_wr) begin
      unique case (paddr_i)
        `C_ACC_ADDR:   next_s.acc_addr  = pwdata_i[`LINK_AW-1:0];
        `C_ACC_WDATA:  next_s.acc_wdata = pwdata_i;
        `C_CLR_CFG: begin
          next_s.clr_media = pwdata_i[`CFG_MEDIA];
          next_s.clr_blt   = pwdata_i[`CFG_BLT];
          next_s.clr_eir   = pwdata_i[`CFG_EIR_LO +: `ERR_W];
        end
        `C_INT_STATUS: int_clr = pwdata_i[`INT_W-1:0];
        `C_INT_MASK:   next_s.int_mask = pwdata_i[`INT_W-1:0];
        default: begin
        end
      endcase
    end

    // Orders while busy are dropped
    if (s.seq == S_IDLE && apb_wr && paddr_i == `C_CTRL) begin
      if (pwdata_i[`CTRL_START]) begin
        next_s.seq = step_after(S_IDLE, s);
      end else if (pwdata_i[`CTRL_GO]) begin
        next_s.seq    = S_ACC;
        next_s.acc_we = pwdata_i[`CTRL_WR];
      end
    end else if (s.seq != S_IDLE && lk.ack) begin
      if (s.seq == S_ACC) begin
        int_set[`INT_ACC] = 1'b1;
        if (!s.acc_we) begin
          next_s.acc_rdata = lk.rdata;
        end
      end else if (s.seq == S_IIR) begin
        int_set[`INT_SEQ] = 1'b1;
      end
      next_s.seq = step_after(s.seq, s);
    end

    // Request held from flops until the recorder answers
    next_s.req   = (next_s.seq != S_IDLE);
    next_s.we    = 1'b1;
    next_s.wdata = '0;
    next_s.addr  = '0;
    unique case (next_s.seq)
      S_MED: next_s.addr = `MEDIA_REC_OFS;
      S_BLT: next_s.addr = `BLT_REC_OFS;
      S_EIR: begin
        next_s.addr  = `EIR_OFS;
        next_s.wdata = `DATA_W'(next_s.clr_eir);
      end
      S_IIR: begin
        next_s.addr = `IIR_OFS;
        next_s.wdata[`IIR_MASTER_BIT] = 1'b1;
      end
      S_ACC: begin
        next_s.addr  = next_s.acc_addr;
        next_s.we    = next_s.acc_we;
        next_s.wdata = next_s.acc_wdata;
      end
      default: next_s.req = 1'b0;
    endcase

    next_s.merr_q = lk.master_err;
    int_set[`INT_MERR] = lk.master_err && !s.merr_q;
    // New events win over a write-one clear
    next_s.int_st = (s.int_st & ~int_clr) | int_set;
    next_s.irq    = |(next_s.int_st & next_s.int_mask);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s     <= '0;
      s.seq <= S_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign lk.req    = s.req;
  assign lk.we     = s.we;
  assign lk.addr   = s.addr;
  assign lk.wdata  = s.wdata;
  assign prdata_o  = s.prdata;
  assign pready_o  = s.pready;
  assign pslverr_o = 1'b0;
  assign irq_o     = s.irq;

endmodule

// file: fault_link_asserts.sv
// Link checker for the fault recorder and its clear controller.
// Assumes one clock domain; sees the link signals as plain inputs.
`include "fault_cfg.svh"
`timescale 1ns/1ps
module fault_link_asserts (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                req,
  input  wire logic                we,
  input  wire logic [`LINK_AW-1:0] addr,
  input  wire logic [`DATA_W-1:0]  wdata,
  input  wire logic                ack,
  input  wire logic [`DATA_W-1:0]  rdata,
  input  wire logic                master_err
);
  logic pend;
  logic rec_rd;
  logic mapped;
  logic iir_req;
  logic eir_wr;
  logic iir_wr;
  assign pend    = req && !ack;
  assign rec_rd  = ack && !we && (addr == `MEDIA_REC_OFS ||
                                  addr == `BLT_REC_OFS);
  assign mapped  = addr == `MEDIA_REC_OFS || addr == `BLT_REC_OFS ||
                   addr == `IIR_OFS || addr == `EIR_OFS ||
                   addr == `ESR_OFS || addr == `EMR_OFS;
  assign iir_req = req && we && addr == `IIR_OFS &&
                   wdata[`IIR_MASTER_BIT];
  assign eir_wr  = ack && we && addr == `EIR_OFS;
  assign iir_wr  = ack && we && addr == `IIR_OFS;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_has_cause_a: assert property (ack |-> $past(pend))
    else $error("ack without a pending request");
  ack_in_time_a: assert property (pend |=> ack)
    else $error("ack not one cycle after request");
  req_held_a: assert property (pend |=> req && $stable(addr) &&
    $stable(we) && $stable(wdata))
    else $error("request changed before ack");
  rsvd_bits_a: assert property (rec_rd |-> rdata[2:1] == 2'b00)
    else $error("reserved record bits not zero");
  cleared_rec_a: assert property (rec_rd && !rdata[0] |->
    rdata[31:1] == 31'h0)
    else $error("invalid record holds stale fields");
  unmapped_zero_a: assert property (ack && !we && !mapped |->
    rdata == 32'h0)
    else $error("unmapped read not zero");
  master_raise_a: assert property (ack && !we && addr == `EIR_OFS &&
    rdata != 32'h0 |-> ##[0:2] master_err)
    else $error("identity bit set without master error");
  master_clear_a: assert property ($fell(master_err) |->
    $past(iir_req))
    else $error("master error fell without identity write");
  clear_order_a: assert property (iir_wr |-> $past(eir_wr, 2))
    else $error("master cleared before identity bits");

  cover property (iir_wr);
  cover property ($rose(master_err));
  cover property (rec_rd && rdata[0]);
  cover property (eir_wr);
endmodule

// file: page_fault_record_error_clear_tb.sv
// Bench for the fault recorder joined to its clear controller.
// Assumes the shared header and package; APB driven by the bench.
`include "fault_cfg.svh"
`timescale 1ns/1ps
module page_fault_record_error_clear_tb;
  logic        clk_i, rst_i, psel, penable, pwrite, pready, pslverr;
  logic        irq, media_fault, media_sel, blt_fault, blt_sel;
  logic        pgtbl_err, media_inv, blt_inv;
  logic [7:0]  paddr, media_src, blt_src, ev;
  logic [31:0] pwdata, prdata, q;
  logic [19:0] media_vpage, blt_vpage, vm, vb;
  logic [7:0]  im, ib;
  logic        sm, sb;
  logic [4:0]  op_err, op;
  int          err_count, samples_checked, seed, i;

  fault_link_if lk ();
  fault_recorder fault_recorder_i (.clk_i(clk_i), .rst_i(rst_i), .lk(lk),
    .media_fault_i(media_fault), .media_vpage_i(media_vpage),
    .media_sel_i(media_sel), .media_src_i(media_src),
    .blt_fault_i(blt_fault), .blt_vpage_i(blt_vpage),
    .blt_sel_i(blt_sel), .blt_src_i(blt_src), .pgtbl_err_i(pgtbl_err),
    .op_err_i(op_err), .media_cycle_invalid_o(media_inv),
    .blt_cycle_invalid_o(blt_inv));
  fault_clear_ctl fault_clear_ctl_i (.clk_i(clk_i), .rst_i(rst_i),
    .lk(lk), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq));
  fault_link_asserts fault_link_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
    .req(lk.req), .we(lk.we), .addr(lk.addr), .wdata(lk.wdata),
    .ack(lk.ack), .rdata(lk.rdata), .master_err(lk.master_err));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_idle;
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      apb(1'b0, `C_STATUS, 32'h0, s);
      n++;
    end while (s[0] !== 1'b0 && n < 50);
    if (n >= 50) chk(s, 32'h0);
  endtask

  // Single link access; controller polled until idle
  task acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, `C_ACC_ADDR, {16'h0, a}, q);
    apb(1'b1, `C_ACC_WDATA, d, q);
    apb(1'b1, `C_CTRL, {29'h0, w, 2'b10}, q);
    wait_idle();
    apb(1'b0, `C_ACC_RDATA, 32'h0, q);
  endtask

  task rd_chk(input logic [15:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  // Inputs scrambled after the strobe: only the strobe cycle may count
  task fault(input logic e, input logic [19:0] v, input logic s,
             input logic [7:0] id);
    @(posedge clk_i);
    {blt_fault, media_fault} <= e ? 2'b10 : 2'b01;
    {media_vpage, media_sel, media_src} <= {v, s, id};
    {blt_vpage, blt_sel, blt_src} <= {v, s, id};
    @(posedge clk_i);
    {blt_fault, media_fault} <= 2'b00;
    {media_vpage, media_sel, media_src} <= ~{v, s, id};
    {blt_vpage, blt_sel, blt_src} <= ~{v, s, id};
    #1 chk({31'h0, e ? blt_inv : media_inv}, 32'h1);
  endtask

  task clr(input logic [31:0] cfg);
    apb(1'b1, `C_CLR_CFG, cfg, q);
    apb(1'b1, `C_CTRL, 32'h1, q);
    wait_idle();
  endtask

  function automatic logic [31:0] rec(logic [19:0] v, logic s,
                                      logic [7:0] id);
    return {v, s, id, 2'b00, 1'b1};
  endfunction

  initial begin
    #500000;
    err_count++;
    complete_run();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {media_fault, media_vpage, media_sel, media_src} = '0;
    {blt_fault, blt_vpage, blt_sel, blt_src, pgtbl_err, op_err} = '0;
    err_count = 0;
    samples_checked = 0;
    seed = 53630;
    rst_i = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(`MEDIA_REC_OFS, 32'h0);
    rd_chk(`BLT_REC_OFS, 32'h0);
    rd_chk(16'h4000, 32'h0);
    // Mask register must come out of reset with every error masked
    rd_chk(`EMR_OFS, {24'h0, `EMR_RST});
    chk({31'h0, pslverr}, 32'h0);
    apb(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h0);
    acc(1'b1, `EMR_OFS, 32'h0);
    apb(1'b1, `C_INT_MASK, 32'h1, q);
    for (i = 0; i < 4; i++) begin
      // Corner cases first: all ones in every media field in round 0, all zeros in every blitter field in round 1
      {vm, sm, im} = (i == 0) ? 29'h1FFFFFFF : 29'($random(seed));
      {vb, sb, ib} = (i == 1) ? 29'h0 : 29'($random(seed));
      op = 5'($random(seed)) | 5'h01;
      fault(1'b0, vm, sm, im);
      fault(1'b1, vb, sb, ib);
      fault(1'b0, ~vm, ~sm, ~im);
      fault(1'b1, ~vb, ~sb, ~ib);
      @(posedge clk_i) op_err <= op;
      @(posedge clk_i) op_err <= 5'h0;
      rd_chk(`MEDIA_REC_OFS, rec(vm, sm, im));
      rd_chk(`BLT_REC_OFS, rec(vb, sb, ib));
      ev = {op, 2'b11, 1'b0};
      acc(1'b1, `EIR_OFS, 32'h0);
      rd_chk(`EIR_OFS, {24'h0, ev});
      apb(1'b0, `C_STATUS, 32'h0, q);
      chk({31'h0, q[1]}, 32'h1);
      clr({16'h0, ev, 8'h03});
      rd_chk(`MEDIA_REC_OFS, 32'h0);
      rd_chk(`BLT_REC_OFS, 32'h0);
      rd_chk(`EIR_OFS, 32'h0);
      rd_chk(`ESR_OFS, 32'h0);
      apb(1'b0, `C_STATUS, 32'h0, q);
      chk({31'h0, q[1]}, 32'h0);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, `C_INT_STATUS, 32'h1, q);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq}, 32'h0);
      $display("fault round %0d done", i);
    end
    // Masked done event must not reach the interrupt line
    apb(1'b1, `C_INT_MASK, 32'h0, q);
    clr(32'h0);
    apb(1'b0, `C_INT_STATUS, 32'h0, q);
    chk({31'h0, q[0]}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `C_INT_STATUS, 32'h7, q);
    apb(1'b1, `C_INT_MASK, 32'h4, q);
    $display("interrupt mask test done");
    @(posedge clk_i) pgtbl_err <= 1'b1;
    @(posedge clk_i) pgtbl_err <= 1'b0;
    clr(32'hFF00);
    rd_chk(`EIR_OFS, 32'h1);
    apb(1'b0, `C_STATUS, 32'h0, q);
    chk({31'h0, q[1]}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    $display("page table error test done");
    complete_run();
  end
endmodule
